// ===== hw/adcseq_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "adcseq_map.svh"

module adcseq_top
   import adcseq_pkg::*;
#(
   parameter int THIRD_CLKS = (`ADC_TCYC_NS / 3) / `ADC_CLK_NS
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic comp_above,
   output logic [3:0] channel_select,
   output logic [11:0] sar_trial,
   output logic converter_active,
   output logic conversion_irq
);

   localparam logic [7:0] THIRD_LAST = 8'(THIRD_CLKS - 1);

   localparam adcseq_regs_t RESET_STATE = '{
      state: ADCSEQ_IDLE,
      ctrl: `ADC_RESET_VAL,
      mode: `ADC_RESET_VAL,
      res_lo: `ADC_RESET_VAL,
      res_hi: `ADC_RESET_VAL,
      dbl_pend: 1'b1,
      third_cnt: 8'h00,
      dur_cnt: 15'h0000,
      bit_cnt: 11'h000,
      bits_left: 4'h0,
      probe: 12'h000,
      trial: 12'h000,
      comp_meta: 1'b0,
      comp_sync: 1'b0,
      dph_wr: 1'b0,
      dph_sel: `ADC_SEL_NONE,
      rdata: 8'h00,
      ready: 1'b1,
      irq: 1'b0
   };

   adcseq_regs_t q;
   adcseq_regs_t n;

   function automatic logic [2:0] reg_sel(input logic [31:0] addr);
      if (addr == {14'h0000, `ADC_IDX_CONTROL, 2'b00}) begin
         return 3'h0;
      end else if (addr == {14'h0000, `ADC_IDX_MODE, 2'b00}) begin
         return 3'h1;
      end else if (addr == {14'h0000, `ADC_IDX_RES_LO, 2'b00}) begin
         return 3'h2;
      end else if (addr == {14'h0000, `ADC_IDX_RES_HI, 2'b00}) begin
         return 3'h3;
      end
      return `ADC_SEL_NONE;
   endfunction : reg_sel

   // Whole conversion length in thirds of an instruction cycle
   function automatic logic [14:0] dur_thirds(input logic res8,
                                              input logic [2:0] code,
                                              input logic dbl);
      logic [14:0] base;
      base = (res8 ? 15'(`ADC_MUL_8) : 15'(`ADC_MUL_12)) << code;
      base = base + 15'(`ADC_CONV_EXTRA);
      return dbl ? (base << 1) : base;
   endfunction : dur_thirds

   // One approximation step; fits inside the whole length for all codes
   function automatic logic [10:0] bit_thirds(input logic [2:0] code,
                                              input logic dbl);
      logic [10:0] per;
      per = 11'(`ADC_BIT_THIRDS) << code;
      return dbl ? (per << 1) : per;
   endfunction : bit_thirds

   logic [2:0] div_code;
   logic res8;
   logic dbl_eff;
   logic tick;
   logic done_set;
   logic start;
   logic [7:0] wd;

   always_comb begin
      n = q;
      div_code = {q.res_lo[`ADC_LO_DIV_HI], q.mode[1:0]};
      res8 = q.mode[`ADC_MODE_RES];
      dbl_eff = q.dbl_pend & ~res8;
      tick = 1'b0;
      done_set = 1'b0;
      start = 1'b0;
      wd = hwdata[7:0];

      n.comp_meta = comp_above;
      n.comp_sync = q.comp_meta;
      n.ready = 1'b1;

      unique case (q.state)
         ADCSEQ_IDLE: begin
            n.third_cnt = 8'h00;
         end
         ADCSEQ_CONV: begin
            // Third-cycle enable keeps the length exact when the clock period divides a third of the cycle
            if (q.third_cnt == THIRD_LAST) begin
               tick = 1'b1;
               n.third_cnt = 8'h00;
            end else begin
               n.third_cnt = q.third_cnt + 8'h01;
            end
            if (tick) begin
               n.dur_cnt = q.dur_cnt - 15'h0001;
               if (q.bits_left != 4'h0) begin
                  if (q.bit_cnt == 11'h001) begin
                     n.bit_cnt = bit_thirds(div_code, dbl_eff);
                     n.bits_left = q.bits_left - 4'h1;
                     n.probe = q.probe >> 1;
                     n.trial = q.comp_sync ? q.trial : (q.trial & ~q.probe);
                     if (q.bits_left != 4'h1) begin
                        n.trial = n.trial | (q.probe >> 1);
                     end
                  end else begin
                     n.bit_cnt = q.bit_cnt - 11'h001;
                  end
               end
               if (q.dur_cnt == 15'h0001) begin
                  done_set = 1'b1;
               end
            end
         end
      endcase

      // Data phase of a write: the register takes the low byte
      if (q.dph_wr) begin
         unique case (q.dph_sel)
            3'h0: begin
               n.ctrl = wd;
               if (wd[`ADC_CTL_GO] && q.state == ADCSEQ_IDLE) begin
                  start = 1'b1;
               end else if (!wd[`ADC_CTL_GO] && q.state == ADCSEQ_CONV) begin
                  // Abort leaves the result registers unsettled
                  n.state = ADCSEQ_IDLE;
               end
            end
            3'h1: begin
               n.mode = wd;
               if (q.mode[`ADC_MODE_RES] && !wd[`ADC_MODE_RES]) begin
                  n.dbl_pend = 1'b1;
               end
            end
            3'h2: n.res_lo = wd;
            3'h3: n.res_hi = wd;
            default: begin
            end
         endcase
      end

      if (start) begin
         n.state = ADCSEQ_CONV;
         n.third_cnt = 8'h00;
         n.dur_cnt = dur_thirds(res8, div_code, dbl_eff);
         n.bit_cnt = bit_thirds(div_code, dbl_eff);
         n.bits_left = res8 ? `ADC_BITS_8 : `ADC_BITS_12;
         n.probe = `ADC_SAR_MSB;
         n.trial = `ADC_SAR_MSB;
         if (!res8) begin
            n.dbl_pend = 1'b0;
         end
      end

      // Completion beats a same-cycle write: done set wins over clear
      if (done_set) begin
         n.state = ADCSEQ_IDLE;
         n.ctrl[`ADC_CTL_GO] = 1'b0;
         n.ctrl[`ADC_CTL_DONE] = 1'b1;
         n.res_hi = q.trial[11:4];
         if (!res8) begin
            n.res_lo[7:4] = q.trial[3:0];
         end
      end

      if (n.state == ADCSEQ_IDLE) begin
         n.probe = 12'h000;
         n.trial = 12'h000;
      end

      n.irq = n.ctrl[`ADC_CTL_IE] & n.ctrl[`ADC_CTL_DONE];

      // Address phase; read data comes from the updated copy
      n.dph_wr = 1'b0;
      n.dph_sel = `ADC_SEL_NONE;
      if (hsel && hready && htrans[1]) begin
         n.dph_wr = hwrite;
         n.dph_sel = reg_sel(haddr);
         n.rdata = 8'h00;
         if (!hwrite) begin
            unique case (reg_sel(haddr))
               3'h0: n.rdata = n.ctrl;
               3'h1: n.rdata = n.mode;
               3'h2: n.rdata = n.res_lo;
               3'h3: n.rdata = n.res_hi;
               default: n.rdata = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         q <= RESET_STATE;
      end else begin
         q <= n;
      end
   end

   assign hreadyout = q.ready;
   assign hresp = 1'b0;
   assign hrdata = {24'h000000, q.rdata};
   assign channel_select = q.ctrl[7:4];
   assign sar_trial = q.trial;
   assign converter_active = q.state[1];
   assign conversion_irq = q.irq;

endmodule : adcseq_top
`default_nettype wire

// ===== hw/adcseq_map.svh
`ifndef ADCSEQ_MAP_SVH
`define ADCSEQ_MAP_SVH
`define ADC_IDX_CONTROL 16'hFE58
`define ADC_IDX_MODE 16'hFE59
`define ADC_IDX_RES_LO 16'hFE5A
`define ADC_IDX_RES_HI 16'hFE5B
`define ADC_RESET_VAL 8'h00
`define ADC_CTL_GO 2
`define ADC_CTL_DONE 1
`define ADC_CTL_IE 0
`define ADC_MODE_RES 6
`define ADC_LO_DIV_HI 0
`define ADC_MUL_12 52
`define ADC_MUL_8 32
`define ADC_CONV_EXTRA 2
`define ADC_BIT_THIRDS 4
`define ADC_BITS_12 4'hC
`define ADC_BITS_8 4'h8
`define ADC_SAR_MSB 12'h800
`define ADC_TCYC_NS 30
`define ADC_CLK_NS 10
`define ADC_SEL_NONE 3'h4
`endif

// ===== hw/adcseq_pkg.sv
package adcseq_pkg;
   typedef enum logic [1:0] {
      ADCSEQ_IDLE = 2'b01,
      ADCSEQ_CONV = 2'b10
   } adcseq_state_t;

   typedef struct packed {
      adcseq_state_t state;
      logic [7:0] ctrl;
      logic [7:0] mode;
      logic [7:0] res_lo;
      logic [7:0] res_hi;
      logic dbl_pend;
      logic [7:0] third_cnt;
      logic [14:0] dur_cnt;
      logic [10:0] bit_cnt;
      logic [3:0] bits_left;
      logic [11:0] probe;
      logic [11:0] trial;
      logic comp_meta;
      logic comp_sync;
      logic dph_wr;
      logic [2:0] dph_sel;
      logic [7:0] rdata;
      logic ready;
      logic irq;
   } adcseq_regs_t;
endpackage : adcseq_pkg

// ===== tb/adcseq_sva.sv
`timescale 1ns/100ps
`default_nettype none
module adcseq_sva (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hreadyout,
   input wire logic [3:0] channel_select,
   input wire logic [11:0] sar_trial,
   input wire logic converter_active,
   input wire logic conversion_irq
);
   logic wc;
   assign wc = hreadyout && htrans[1] && hwrite && haddr == 32'h0003F960;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   chk_reset_halt: assert property (disable iff (1'b0)
      !rst_b |=> !converter_active) else $error("not halted");
   chk_idle_trial: assert property (
      !converter_active |-> sar_trial == 12'h000) else $error("trial");
   chk_start_msb: assert property (
      $rose(converter_active) |-> sar_trial == 12'h800) else $error("msb");
   chk_start_cause: assert property (
      $rose(converter_active) |-> $past(wc, 2) && $past(hwdata[2]))
      else $error("start");
   chk_abort_stop: assert property (
      wc ##1 (!hwdata[2] && converter_active) |=> !converter_active)
      else $error("abort");
   chk_chan_write: assert property (
      $changed(channel_select) && $past(rst_b) |-> $past(wc, 2))
      else $error("channel");
   chk_irq_clear: assert property (
      $fell(conversion_irq) && $past(rst_b) |-> $past(wc, 2))
      else $error("irq fell");
   chk_irq_raise: assert property (
      $rose(conversion_irq) |-> $fell(converter_active) || $past(wc, 2))
      else $error("irq rose");
endmodule : adcseq_sva
bind adcseq_top adcseq_sva chk (.*);
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam logic [31:0] A0 = 32'h0003F960;
   logic clock = 0, rst_b = 0, hsel = 1, hwrite = 0, comp_above = 0;
   logic dbl = 1, w8 = 0, hreadyout, hresp, converter_active;
   logic conversion_irq;
   logic [1:0] htrans = '0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [3:0] channel_select;
   logic [11:0] sar_trial, vin = '0;
   integer seed = 57, miscompares = 0, samples_checked = 0, cyc = 0, n;
   adcseq_top dut (.clock, .rst_b, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hready(hreadyout), .hwdata, .hreadyout, .hresp,
      .hrdata, .comp_above, .channel_select, .sar_trial,
      .converter_active, .conversion_irq);
   initial begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      // Input sits half a code above vin
      comp_above <= (sar_trial <= vin);
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         miscompares++;
         test_done;
      end
   end
   task automatic cmp(input logic [15:0] g, e);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp
   task automatic xfer(input logic [2:0] i, input logic w,
      input logic [7:0] d);
      @(posedge clock);
      haddr <= A0 + {27'h0000000, i, 2'h0};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      do @(posedge clock); while (hreadyout !== 1'b1);
      if (!w)
         cmp({8'h00, hrdata[7:0]}, {8'h00, d});
   endtask : xfer
   task automatic conv(input logic r8, input logic [2:0] c);
      logic [15:0] t;
      vin = 12'($random(seed));
      dbl = dbl | (w8 & !r8);
      w8 = r8;
      t = ((r8 ? 16'h0020 : 16'h0034) << c) + 16'h0002;
      t = (dbl & !r8) ? t * 2 : t;
      dbl = dbl & r8;
      xfer(3'h2, 1'b1, {4'hA, 3'h0, c[2]});
      xfer(3'h1, 1'b1, {1'b0, r8, 4'h0, c[1:0]});
      xfer(3'h0, 1'b1, 8'h55);
      n = 0;
      do begin
         @(posedge clock);
         #1 n++;
      end while (converter_active === 1'b1 && n < 9000);
      cmp(16'(n), t);
      cmp(16'(conversion_irq), 16'h0001);
      xfer(3'h0, 1'b0, 8'h53);
      xfer(3'h3, 1'b0, vin[11:4]);
      xfer(3'h2, 1'b0, {r8 ? 4'hA : vin[3:0], 3'h0, c[2]});
      xfer(3'h0, 1'b1, 8'h51);
      #1 cmp(16'(conversion_irq), 16'h0000);
   endtask : conv
   task automatic test_done;
      $display("checks %0d errors %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done
   initial begin
      repeat (12) @(posedge clock);
      rst_b <= 1'b1;
      for (int i = 0; i < 5; i++)
         xfer(3'(i), 1'b0, 8'h00);
      for (int i = 0; i < 16; i++)
         if (i < 8 || i == 9 || i == 15) begin
            xfer(3'h0, 1'b1, 8'(i * 16));
            #1 cmp(16'(channel_select), 16'(i));
         end
      conv(1'b0, 3'h0);
      conv(1'b0, 3'h1);
      conv(1'b1, 3'h7);
      conv(1'b1, 3'h2);
      conv(1'b0, 3'h3);
      conv(1'b0, 3'h5);
      xfer(3'h0, 1'b1, 8'h55);
      repeat (10) @(posedge clock);
      xfer(3'h0, 1'b1, 8'h51);
      #1 cmp(16'(converter_active), 16'h0000);
      xfer(3'h0, 1'b0, 8'h51);
      xfer(3'h0, 1'b1, 8'h55);
      repeat (5) @(posedge clock);
      rst_b <= 1'b0;
      @(posedge clock);
      rst_b <= 1'b1;
      dbl = 1;
      w8 = 0;
      #1 cmp(16'(converter_active), 16'h0000);
      xfer(3'h0, 1'b0, 8'h00);
      conv(1'b0, 3'h0);
      test_done;
   end
endmodule : tb
`default_nettype wire
